/* hw/psa_defs.svh */
`ifndef PSA_DEFS_SVH
`define PSA_DEFS_SVH

`define PSA_CORE_MHZ        125
`define PSA_PEAK_MHZ        20
`define PSA_PEAK_DIV        (`PSA_CORE_MHZ / `PSA_PEAK_MHZ)
`define PSA_GAIN_LIMIT_NS   100
`define PSA_GAIN_LIMIT_CYC  ((`PSA_GAIN_LIMIT_NS * `PSA_CORE_MHZ) / 1000)
`define PSA_I2S_DIV         4

`define PSA_OFS_CTRL        8'h00
`define PSA_OFS_PRE         8'h04
`define PSA_OFS_POST        8'h08
`define PSA_OFS_TRIG        8'h0c
`define PSA_OFS_BASE        8'h10
`define PSA_OFS_STAT        8'h14
`define PSA_OFS_RESULT      8'h18
`define PSA_OFS_CMD         8'h1c
`define PSA_OFS_TADDR       8'h20
`define PSA_OFS_CHOP        8'h24
`define PSA_OFS_LAST        8'h28

`define PSA_CTRL_ARM        0
`define PSA_CTRL_EQ         1
`define PSA_CTRL_RANGE_REL  2

`define PSA_ST_OVL          0
`define PSA_ST_SENS         1
`define PSA_ST_DSP          2
`define PSA_ST_DONE         3
`define PSA_ST_OVR          4
`define PSA_ST_BUSY         5
`define PSA_ST_PRESENT      6
`define PSA_ST_ATT16        7
`define PSA_ST_RANGE        8

`define PSA_PRE_RST         16'h0010
`define PSA_POST_RST        16'h0010
`define PSA_TRIG_RST        12'h100
`define PSA_BASE_RST        12'h800
`define PSA_CHOP_RST        8'h10

`endif

/* hw/psa_pkg.sv */
package psa_pkg;
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_PRE  = 2'b01,
    CAP_WAIT = 2'b10,
    CAP_POST = 2'b11
  } psa_cap_state_type;
endpackage

/* hw/psa_capture.sv */
`timescale 1ns/100ps
module psa_capture (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_arm,
  input  wire logic        i_sample_valid,
  input  wire logic [11:0] i_level,
  input  wire logic [15:0] i_word,
  input  wire logic [15:0] i_pre,
  input  wire logic [15:0] i_post,
  input  wire logic [11:0] i_trig_level,
  input  wire logic        i_mem_ready,
  output logic             o_mem_we,
  output logic [23:0]      o_mem_addr,
  output logic [15:0]      o_mem_data,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_overrun,
  output logic [23:0]      o_trig_addr
);
  psa_pkg::psa_cap_state_type state_r;
  logic [15:0]                cnt_r;
  logic [15:0]                ring_r;
  logic [15:0]                ring_nxt;
  logic                       write_now;
  logic [23:0]                write_addr;

  assign ring_nxt = (16'(ring_r + 16'h0001) == i_pre) ? 16'h0000 : 16'(ring_r + 16'h0001);

  // The pre-trigger area is a ring at 0..pre-1; the trigger sample and the rest follow at pre.
  always_comb begin
    write_now  = 1'b0;
    write_addr = {8'h00, ring_r};
    case (state_r)
      psa_pkg::CAP_PRE: begin
        write_now = i_sample_valid;
      end
      psa_pkg::CAP_WAIT: begin
        write_now = i_sample_valid && ((i_level >= i_trig_level) || (i_pre != 16'h0000));
        if (i_level >= i_trig_level) begin
          write_addr = {8'h00, i_pre};
        end
      end
      psa_pkg::CAP_POST: begin
        write_now  = i_sample_valid;
        write_addr = 24'(i_pre) + 24'(cnt_r);
      end
      default: begin
        write_now = 1'b0;
      end
    endcase
  end

  // A sample that meets a busy memory is lost and flagged, since the converter cannot be paused.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_we   <= 1'b0;
      o_mem_addr <= 24'h000000;
      o_mem_data <= 16'h0000;
      o_overrun  <= 1'b0;
    end else begin
      o_mem_we   <= write_now && i_mem_ready;
      o_overrun  <= write_now && !i_mem_ready;
      if (write_now) begin
        o_mem_addr <= write_addr;
        o_mem_data <= i_word;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r     <= psa_pkg::CAP_IDLE;
      cnt_r       <= 16'h0000;
      ring_r      <= 16'h0000;
      o_busy      <= 1'b0;
      o_done      <= 1'b0;
      o_trig_addr <= 24'h000000;
    end else begin
      o_done <= 1'b0;
      case (state_r)
        psa_pkg::CAP_IDLE: begin
          if (i_arm) begin
            state_r <= (i_pre == 16'h0000) ? psa_pkg::CAP_WAIT : psa_pkg::CAP_PRE;
            cnt_r   <= 16'h0000;
            ring_r  <= 16'h0000;
            o_busy  <= 1'b1;
          end
        end
        psa_pkg::CAP_PRE: begin
          if (i_sample_valid) begin
            ring_r <= ring_nxt;
            cnt_r  <= 16'(cnt_r + 16'h0001);
            if (16'(cnt_r + 16'h0001) == i_pre) begin
              state_r <= psa_pkg::CAP_WAIT;
            end
          end
        end
        psa_pkg::CAP_WAIT: begin
          if (i_sample_valid) begin
            if (i_level >= i_trig_level) begin
              o_trig_addr <= {8'h00, ring_r};
              cnt_r       <= 16'h0001;
              if (i_post <= 16'h0001) begin
                state_r <= psa_pkg::CAP_IDLE;
                o_busy  <= 1'b0;
                o_done  <= 1'b1;
              end else begin
                state_r <= psa_pkg::CAP_POST;
              end
            end else if (i_pre != 16'h0000) begin
              ring_r <= ring_nxt;
            end
          end
        end
        psa_pkg::CAP_POST: begin
          if (i_sample_valid) begin
            cnt_r <= 16'(cnt_r + 16'h0001);
            if (16'(cnt_r + 16'h0001) == i_post) begin
              state_r <= psa_pkg::CAP_IDLE;
              o_busy  <= 1'b0;
              o_done  <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= psa_pkg::CAP_IDLE;
        end
      endcase
    end
  end
endmodule

/* hw/psa_i2s_tx.sv */
`timescale 1ns/100ps
`include "psa_defs.svh"
module psa_i2s_tx (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_left,
  input  wire logic [15:0] i_right,
  output logic             o_bclk,
  output logic             o_lrclk,
  output logic             o_sdata,
  output logic             o_frame
);
  logic [7:0]  div_r;
  logic [4:0]  bit_r;
  logic [4:0]  bit_nxt;
  logic [31:0] word_r;
  logic        fall;

  assign fall    = o_bclk && (div_r == 8'(`PSA_I2S_DIV - 1));
  assign bit_nxt = 5'(bit_r + 5'h01);

  // Data and word select change on the falling bit clock so the receiver samples mid-bit.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r   <= 8'h00;
      o_bclk  <= 1'b0;
      bit_r   <= 5'h1f;
      word_r  <= 32'h00000000;
      o_lrclk <= 1'b0;
      o_sdata <= 1'b0;
      o_frame <= 1'b0;
    end else begin
      o_frame <= 1'b0;
      if (div_r == 8'(`PSA_I2S_DIV - 1)) begin
        div_r  <= 8'h00;
        o_bclk <= ~o_bclk;
      end else begin
        div_r <= 8'(div_r + 8'h01);
      end
      if (fall) begin
        bit_r   <= bit_nxt;
        o_lrclk <= (bit_nxt >= 5'h0f) && (bit_nxt != 5'h1f);
        if (bit_nxt == 5'h00) begin
          word_r  <= {i_left, i_right};
          o_sdata <= i_left[15];
          o_frame <= 1'b1;
        end else begin
          o_sdata <= word_r[5'h1f - bit_nxt];
        end
      end
    end
  end
endmodule

/* hw/psa_ctrl.sv */
// Overview of operation
// - Pick attenuation 1 or 16 from comparator.
// - Gain switched well inside 100 ns.
// - Take signed 12-bit peak samples at 20 MHz; the divider of 6 gives about 20.8 MHz.
// - Baseline near -2048 counts as zero signal.
// - Store each sample with gain and range.
// - Triggered capture with pre, post, level.
// - Overload trip raises host interrupt.
// - Overload trip forces sensor upper range.
// - Average sampling locked to chop period.
// - Average samples sent out over I2S.
// - 32-bit average result held for host.
// - Host and DSP traffic bridged here.
// - Equalizer on only for fast-settling sensors.
// - Sensor attach or detach interrupts host.
// - All clocks derived from one system clock.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "psa_defs.svh"
module psa_ctrl (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [31:0]      o_reg_rdata,
  input  wire logic        i_level_cmp,
  input  wire logic [11:0] i_peak_adc_data,
  output logic             o_peak_adc_clk,
  output logic             o_peak_gain_select_switch,
  output logic             o_mem_we,
  output logic [23:0]      o_mem_addr,
  output logic [15:0]      o_mem_data,
  input  wire logic        i_mem_ready,
  input  wire logic        i_overload_cmp,
  output logic             o_sensor_upper_range_force,
  input  wire logic        i_sensor_present,
  output logic             o_host_irq,
  output logic             o_equalizer_on,
  output logic             o_avg_conv_start,
  input  wire logic [15:0] i_avg_data_lo,
  input  wire logic [15:0] i_avg_data_hi,
  output logic             o_chop_drive,
  output logic             o_i2s_bclk,
  output logic             o_i2s_lrclk,
  output logic             o_i2s_sdata,
  output logic [31:0]      o_dsp_cmd,
  output logic             o_dsp_cmd_valid,
  input  wire logic [31:0] i_dsp_result,
  input  wire logic        i_dsp_result_we,
  input  wire logic        i_dsp_irq
);
  // Pins from outside: bit 0 level comparator, bit 1 overload, bit 2 sensor present.
  logic [2:0]  pin_in;
  logic [2:0]  sy1_r;
  logic [2:0]  sy2_r;
  logic [2:0]  sy3_r;
  logic [2:0]  stab_r;
  logic [2:0]  stab_d_r;
  logic [2:0]  prime_r;

  logic [15:0] pre_r;
  logic [15:0] post_r;
  logic [11:0] trig_r;
  logic [11:0] base_r;
  logic [7:0]  chop_half_r;
  logic        eq_r;
  logic        arm_r;
  logic        range_rel_r;
  logic [3:0]  sticky_r;
  logic [3:0]  sticky_set;
  logic [3:0]  sticky_clr;
  logic [31:0] result_r;

  logic [7:0]  pdiv_r;
  logic [11:0] sample_r;
  logic        sample_valid_r;
  logic [11:0] level_r;
  logic [15:0] last_word_r;

  logic [7:0]  chop_cnt_r;
  logic [15:0] avg_lo_r;
  logic [15:0] avg_hi_r;
  logic        frame;

  logic        cap_busy;
  logic        cap_done;
  logic        cap_overrun;
  logic [23:0] cap_trig_addr;
  logic        wr_hit;

  // Subtracts the programmed baseline and floors at zero, so the near-full-scale negative
  // idle code is read as no signal rather than an underflow.
  function automatic logic [11:0] baseline_level(input logic [11:0] smp, input logic [11:0] base);
    logic [12:0] diff;
    diff = 13'({smp[11], smp} - {base[11], base});
    if (diff[12] && (smp[11] == base[11] || smp[11])) begin
      baseline_level = 12'h000;
    end else if (diff[12]) begin
      baseline_level = 12'hfff;
    end else begin
      baseline_level = diff[11:0];
    end
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  assign pin_in = {i_sensor_present, i_overload_cmp, i_level_cmp};
  assign wr_hit = i_reg_wr;

  // Three-stage synchroniser; a level is accepted only once stages two and three agree.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sy1_r    <= 3'h0;
      sy2_r    <= 3'h0;
      sy3_r    <= 3'h0;
      stab_r   <= 3'h0;
      stab_d_r <= 3'h0;
      prime_r  <= 3'h0;
    end else begin
      sy1_r    <= pin_in;
      sy2_r    <= sy1_r;
      sy3_r    <= sy2_r;
      stab_r   <= (sy2_r & sy3_r) | (stab_r & (sy2_r | sy3_r));
      stab_d_r <= stab_r;
      prime_r  <= {prime_r[1:0], 1'b1};
    end
  end

  // Path from comparator pin to switch is five edges (40 ns), inside PSA_GAIN_LIMIT_CYC.
  // The path stays at attenuation 16 for three edges after reset, one edge before stab_r holds a real decision.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_peak_gain_select_switch <= 1'b0;
    end else if (prime_r[2]) begin
      o_peak_gain_select_switch <= ~stab_r[0];
    end
  end

  // Overload forces upper range at once; software may release it only once the trip is gone.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sensor_upper_range_force <= 1'b1;
    end else if (stab_r[1]) begin
      o_sensor_upper_range_force <= 1'b1;
    end else if (range_rel_r) begin
      o_sensor_upper_range_force <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_equalizer_on <= 1'b0;
    end else begin
      o_equalizer_on <= eq_r;
    end
  end

  // Converter clock divided from the core clock; data is taken just before its rising edge.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pdiv_r         <= 8'h00;
      o_peak_adc_clk <= 1'b0;
      sample_r       <= 12'h800;
      sample_valid_r <= 1'b0;
      level_r        <= 12'h000;
    end else begin
      sample_valid_r <= 1'b0;
      if (pdiv_r == 8'(`PSA_PEAK_DIV - 1)) begin
        pdiv_r         <= 8'h00;
        sample_r       <= i_peak_adc_data;
        sample_valid_r <= 1'b1;
        level_r        <= baseline_level(i_peak_adc_data, base_r);
      end else begin
        pdiv_r <= 8'(pdiv_r + 8'h01);
      end
      o_peak_adc_clk <= (pdiv_r == 8'(`PSA_PEAK_DIV - 1)) || (pdiv_r < 8'(`PSA_PEAK_DIV / 2 - 1));
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      last_word_r <= 16'h0000;
    end else if (sample_valid_r) begin
      last_word_r <= {o_sensor_upper_range_force, ~o_peak_gain_select_switch, 2'b00, sample_r};
    end
  end

  psa_capture u_capture (
    .i_core_clk     (i_core_clk),
    .i_rst          (i_rst),
    .i_arm          (arm_r),
    .i_sample_valid (sample_valid_r),
    .i_level        (level_r),
    .i_word         ({o_sensor_upper_range_force, ~o_peak_gain_select_switch, 2'b00, sample_r}),
    .i_pre          (pre_r),
    .i_post         (post_r),
    .i_trig_level   (trig_r),
    .i_mem_ready    (i_mem_ready),
    .o_mem_we       (o_mem_we),
    .o_mem_addr     (o_mem_addr),
    .o_mem_data     (o_mem_data),
    .o_busy         (cap_busy),
    .o_done         (cap_done),
    .o_overrun      (cap_overrun),
    .o_trig_addr    (cap_trig_addr)
  );

  // Average path: one conversion per I2S frame, chop toggled every chop_half frames,
  // so every chop cycle holds the same whole number of samples.
  psa_i2s_tx u_i2s (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_left     (avg_lo_r),
    .i_right    (avg_hi_r),
    .o_bclk     (o_i2s_bclk),
    .o_lrclk    (o_i2s_lrclk),
    .o_sdata    (o_i2s_sdata),
    .o_frame    (frame)
  );

  // Converter results are read one frame after their start, so the pins are long settled.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avg_conv_start <= 1'b0;
      avg_lo_r         <= 16'h0000;
      avg_hi_r         <= 16'h0000;
      chop_cnt_r       <= 8'h00;
      o_chop_drive     <= 1'b0;
    end else begin
      o_avg_conv_start <= frame;
      if (frame) begin
        avg_lo_r <= i_avg_data_lo;
        avg_hi_r <= i_avg_data_hi;
        if (9'(chop_cnt_r) + 9'h001 >= 9'(chop_half_r)) begin
          chop_cnt_r   <= 8'h00;
          o_chop_drive <= ~o_chop_drive;
        end else begin
          chop_cnt_r <= 8'(chop_cnt_r + 8'h01);
        end
      end
    end
  end

  // Host command writes pass to the DSP as one-cycle strobes with the word beside them.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dsp_cmd       <= 32'h00000000;
      o_dsp_cmd_valid <= 1'b0;
    end else begin
      o_dsp_cmd_valid <= wr_hit && hit(i_reg_addr, `PSA_OFS_CMD);
      if (wr_hit && hit(i_reg_addr, `PSA_OFS_CMD)) begin
        o_dsp_cmd <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      result_r <= 32'h00000000;
    end else if (i_dsp_result_we) begin
      result_r <= i_dsp_result;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_r       <= `PSA_PRE_RST;
      post_r      <= `PSA_POST_RST;
      trig_r      <= `PSA_TRIG_RST;
      base_r      <= `PSA_BASE_RST;
      chop_half_r <= `PSA_CHOP_RST;
      eq_r        <= 1'b0;
      arm_r       <= 1'b0;
      range_rel_r <= 1'b0;
    end else begin
      arm_r       <= wr_hit && hit(i_reg_addr, `PSA_OFS_CTRL) && i_reg_wdata[`PSA_CTRL_ARM];
      range_rel_r <= wr_hit && hit(i_reg_addr, `PSA_OFS_CTRL) && i_reg_wdata[`PSA_CTRL_RANGE_REL];
      if (wr_hit) begin
        case (i_reg_addr)
          `PSA_OFS_CTRL: eq_r        <= i_reg_wdata[`PSA_CTRL_EQ];
          `PSA_OFS_PRE:  pre_r       <= i_reg_wdata[15:0];
          `PSA_OFS_POST: post_r      <= i_reg_wdata[15:0];
          `PSA_OFS_TRIG: trig_r      <= i_reg_wdata[11:0];
          `PSA_OFS_BASE: base_r      <= i_reg_wdata[11:0];
          `PSA_OFS_CHOP: chop_half_r <= i_reg_wdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Sticky events, write one to clear; an event in the clearing cycle survives.
  always_comb begin
    sticky_set[`PSA_ST_OVL]  = stab_r[1] && !stab_d_r[1];
    sticky_set[`PSA_ST_SENS] = (stab_r[2] != stab_d_r[2]) && prime_r[2];
    sticky_set[`PSA_ST_DSP]  = i_dsp_irq;
    sticky_set[`PSA_ST_DONE] = cap_done;
    sticky_clr = (wr_hit && hit(i_reg_addr, `PSA_OFS_STAT)) ? i_reg_wdata[3:0] : 4'h0;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sticky_r <= 4'h0;
    end else begin
      sticky_r <= (sticky_r & ~sticky_clr) | sticky_set;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_irq <= 1'b0;
    end else begin
      o_host_irq <= |((sticky_r & ~sticky_clr) | sticky_set);
    end
  end

  logic overrun_r;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      overrun_r <= 1'b0;
    end else begin
      overrun_r <= cap_overrun || (overrun_r &&
                   !(wr_hit && hit(i_reg_addr, `PSA_OFS_STAT) && i_reg_wdata[`PSA_ST_OVR]));
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `PSA_OFS_CTRL:   o_reg_rdata <= {30'h0, eq_r, 1'b0};
        `PSA_OFS_PRE:    o_reg_rdata <= {16'h0000, pre_r};
        `PSA_OFS_POST:   o_reg_rdata <= {16'h0000, post_r};
        `PSA_OFS_TRIG:   o_reg_rdata <= {20'h00000, trig_r};
        `PSA_OFS_BASE:   o_reg_rdata <= {20'h00000, base_r};
        `PSA_OFS_STAT:   o_reg_rdata <= {23'h000000, o_sensor_upper_range_force, ~o_peak_gain_select_switch,
                                         stab_r[2], cap_busy, overrun_r, sticky_r};
        `PSA_OFS_RESULT: o_reg_rdata <= result_r;
        `PSA_OFS_TADDR:  o_reg_rdata <= {8'h00, cap_trig_addr};
        `PSA_OFS_CHOP:   o_reg_rdata <= {24'h000000, chop_half_r};
        `PSA_OFS_LAST:   o_reg_rdata <= {16'h0000, last_word_r};
        default:         o_reg_rdata <= 32'h00000000;
      endcase
    end else begin
      o_reg_rdata <= 32'h00000000;
    end
  end
endmodule

/* test/psa_ctrl_properties.sv */
`timescale 1ns/100ps
module psa_ctrl_checker (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_level_cmp,
  input wire logic        o_peak_gain_select_switch,
  input wire logic        i_overload_cmp,
  input wire logic        o_sensor_upper_range_force,
  input wire logic        o_host_irq,
  input wire logic        o_equalizer_on,
  input wire logic [31:0] o_dsp_cmd,
  input wire logic        o_dsp_cmd_valid,
  input wire logic        o_mem_we,
  input wire logic [15:0] o_mem_data
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // Eight steady cycles keep the switch inside the 100 ns gain budget.
  gain_high_a: assert property ($rose(i_level_cmp) ##1 i_level_cmp [*8] |-> !o_peak_gain_select_switch)
    else $error("gain switch missed a large level");
  gain_low_a: assert property ($fell(i_level_cmp) ##1 !i_level_cmp [*8] |-> o_peak_gain_select_switch)
    else $error("gain switch missed a small level");
  range_trip_a: assert property ($rose(i_overload_cmp) |-> ##[1:6] o_sensor_upper_range_force)
    else $error("overload did not force upper range");
  irq_trip_a: assert property ($rose(i_overload_cmp) |-> ##[1:7] o_host_irq)
    else $error("overload did not raise the interrupt");
  cmd_pass_a: assert property (i_reg_wr && i_reg_addr == 8'h1c |=> o_dsp_cmd_valid && o_dsp_cmd == $past(i_reg_wdata))
    else $error("command word not passed on");
  cmd_only_a: assert property (o_dsp_cmd_valid |-> $past(i_reg_wr) && $past(i_reg_addr) == 8'h1c)
    else $error("command pulse without a write");
  eq_follow_a: assert property (i_reg_wr && i_reg_addr == 8'h00 |-> ##2 o_equalizer_on == $past(i_reg_wdata[1], 2))
    else $error("equalizer does not follow control");
  word_pad_a: assert property (o_mem_we |-> o_mem_data[15:12] ==
    {$past(o_sensor_upper_range_force), ~$past(o_peak_gain_select_switch), 2'b00})
    else $error("sample word range or gain tag wrong");

  cover property ($rose(o_host_irq));
  cover property (o_mem_we);
  cover property (o_dsp_cmd_valid);
endmodule

bind psa_ctrl psa_ctrl_checker psa_ctrl_checker_inst (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_level_cmp(i_level_cmp), .o_peak_gain_select_switch(o_peak_gain_select_switch),
  .i_overload_cmp(i_overload_cmp), .o_sensor_upper_range_force(o_sensor_upper_range_force),
  .o_host_irq(o_host_irq), .o_equalizer_on(o_equalizer_on), .o_dsp_cmd(o_dsp_cmd),
  .o_dsp_cmd_valid(o_dsp_cmd_valid), .o_mem_we(o_mem_we), .o_mem_data(o_mem_data)
);

/* test/psa_dsp_model.sv */
`timescale 1ns/100ps
module psa_dsp_model #(
  parameter int DLY = 3
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [31:0] i_cmd,
  input  wire logic        i_cmd_valid,
  output logic [31:0]      o_result,
  output logic             o_result_we,
  output logic             o_irq
);
  logic [3:0]  cnt_r;
  logic [31:0] hold_r;

  // Outside a write the result bus toggles, so a stale value is never taken.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r       <= 4'h0;
      hold_r      <= 32'h0;
      o_result    <= 32'h0;
      o_result_we <= 1'b0;
      o_irq       <= 1'b0;
    end else begin
      if (i_cmd_valid) begin
        hold_r <= i_cmd;
        cnt_r  <= 4'(DLY);
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
      o_result_we <= (cnt_r == 4'h1);
      o_result    <= (cnt_r == 4'h1) ? hold_r + 32'h1 : ~o_result;
      o_irq       <= o_result_we;
    end
  end
endmodule

/* test/test_psa_ctrl.sv */
`timescale 1ns/100ps
module test_psa_ctrl;
  logic        i_core_clk, i_rst, i_reg_wr, i_reg_rd, i_level_cmp, i_mem_ready;
  logic        i_overload_cmp, i_sensor_present, dsp_we, dsp_irq;
  logic [7:0]  i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, o_dsp_cmd, dsp_res;
  logic [11:0] i_peak_adc_data;
  logic        gain_sw, o_mem_we, range_f, o_host_irq, eq_on, o_dsp_cmd_valid;
  logic [23:0] o_mem_addr;
  logic [15:0] o_mem_data;
  logic [15:0] mem[16];
  int          error_cnt, checks_done, cyc;

  psa_ctrl psa_ctrl_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_level_cmp(i_level_cmp),
    .i_peak_adc_data(i_peak_adc_data), .o_peak_adc_clk(), .o_peak_gain_select_switch(gain_sw),
    .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .i_mem_ready(i_mem_ready),
    .i_overload_cmp(i_overload_cmp), .o_sensor_upper_range_force(range_f),
    .i_sensor_present(i_sensor_present), .o_host_irq(o_host_irq), .o_equalizer_on(eq_on),
    .o_avg_conv_start(), .i_avg_data_lo(16'h1234), .i_avg_data_hi(16'h5678), .o_chop_drive(),
    .o_i2s_bclk(), .o_i2s_lrclk(), .o_i2s_sdata(), .o_dsp_cmd(o_dsp_cmd),
    .o_dsp_cmd_valid(o_dsp_cmd_valid), .i_dsp_result(dsp_res), .i_dsp_result_we(dsp_we), .i_dsp_irq(dsp_irq)
  );

  psa_dsp_model psa_dsp_model_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd(o_dsp_cmd), .i_cmd_valid(o_dsp_cmd_valid),
    .o_result(dsp_res), .o_result_we(dsp_we), .o_irq(dsp_irq)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    if (o_mem_we === 1'b1 && i_mem_ready) begin
      mem[o_mem_addr[3:0]] <= o_mem_data;
    end
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_core_clk);
    d = o_reg_rdata;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [7:0]  a[6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h24, 8'h2c};
    logic [31:0] e[6] = '{32'h10, 32'h10, 32'h100, 32'h800, 32'h10, 32'h0};
    chk(gain_sw, 1'b0);
    chk(range_f, 1'b1);
    for (int i = 0; i < 6; i++) begin
      rd(a[i], d);
      chk(d, e[i]);
    end
    rd(8'h14, d);
    chk(d[8:7], 2'b10);
    $display("reset test done");
  endtask

  // Codes just above the most negative value are the idle baseline, so they must not trigger.
  task automatic t_capture;
    logic [31:0] d;
    int          n;
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h4);
    wr(8'h0c, 32'h10);
    i_peak_adc_data <= 12'h805;
    wr(8'h00, 32'h1);
    wait_cyc(60);
    i_peak_adc_data <= 12'h810;
    n = 0;
    d = 32'h0;
    while (d[3] !== 1'b1 && n < 100) begin
      rd(8'h14, d);
      n++;
    end
    chk(d[3], 1'b1);
    wr(8'h14, 32'h8);
    chk(mem[0], 16'h8805);
    chk(mem[2], 16'h8810);
    chk(mem[5], 16'h8810);
    chk(mem[6], 16'h0);
    $display("capture test done");
  endtask

  task automatic t_gain;
    i_level_cmp <= 1'b1;
    wait_cyc(12);
    chk(gain_sw, 1'b0);
    i_level_cmp <= 1'b0;
    wait_cyc(12);
    chk(gain_sw, 1'b1);
    $display("gain test done");
  endtask

  task automatic t_overload;
    logic [31:0] d;
    wr(8'h00, 32'h4);
    wait_cyc(8);
    chk(range_f, 1'b0);
    chk(o_host_irq, 1'b0);
    i_overload_cmp <= 1'b1;
    wait_cyc(8);
    chk(range_f, 1'b1);
    chk(o_host_irq, 1'b1);
    i_overload_cmp   <= 1'b0;
    i_sensor_present <= 1'b1;
    wait_cyc(8);
    rd(8'h14, d);
    chk(d[1:0], 2'b11);
    wr(8'h14, 32'h3);
    wait_cyc(2);
    chk(o_host_irq, 1'b0);
    chk(range_f, 1'b1);
    $display("overload test done");
  endtask

  task automatic t_bridge;
    logic [31:0] d;
    wr(8'h1c, 32'h1234abcd);
    wait_cyc(10);
    rd(8'h18, d);
    chk(d, 32'h1234abce);
    rd(8'h14, d);
    chk(d[2], 1'b1);
    chk(o_host_irq, 1'b1);
    wr(8'h14, 32'h4);
    wait_cyc(2);
    chk(o_host_irq, 1'b0);
    wr(8'h00, 32'h2);
    wait_cyc(3);
    chk(eq_on, 1'b1);
    wr(8'h00, 32'h0);
    wait_cyc(3);
    chk(eq_on, 1'b0);
    $display("bridge test done");
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    i_rst = 1'b1;
    {i_reg_wr, i_reg_rd, i_level_cmp, i_overload_cmp, i_sensor_present} = 5'h0;
    i_mem_ready = 1'b1;
    i_reg_addr = 8'h0;
    i_reg_wdata = 32'h0;
    i_peak_adc_data = 12'h801;
    foreach (mem[i]) mem[i] = 16'h0;
    wait_cyc(12);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    #1;
    t_reset;
    t_capture;
    t_gain;
    t_overload;
    t_bridge;
    stop_test;
  end
endmodule
